//--- design/sec_bus_err_regs.sv
`timescale 1ns/1ps
`include "sec_err_cfg.svh"


module sec_bus_err_regs
(
    input  wire logic                      clock_i,
    input  wire logic                      ce_i,
    input  wire logic                      rst_i,
    input  wire logic                      pcie_reset_i,
    input  wire logic                      global_reset_in_i,
    input  wire logic                      por_reset_i,
    input  wire logic                      cfg_rd_i,
    input  wire logic                      cfg_wr_i,
    input  wire logic [11:0]               cfg_addr_i,
    input  wire logic [3:0]                cfg_be_i,
    input  wire logic [31:0]               cfg_wdata_i,
    output logic      [31:0]               cfg_rdata_o,
    output logic                           cfg_ack_o,
    output logic                           cfg_hit_o,
    input  wire logic                      sys_err_active_i,
    input  wire logic                      parity_err_signal_active_i,
    input  wire logic                      discard_expired_i,
    input  wire logic                      addr_parity_err_i,
    input  wire logic                      wr_data_parity_err_i,
    input  wire logic                      rd_cpl_perr_i,
    input  wire logic                      master_abort_i,
    input  wire logic                      target_abort_i,
    output logic      [12:0]               err_report_o,
    output logic                           err_report_any_o,
    output logic      [4:0]                err_report_pos_o,
    output logic      [12:0]               sys_err_seen_flag_o
);

    // ************************************************************
    // Helper functions
    // ************************************************************
    function automatic logic [31:0] be_expand(input logic [3:0] be);
        logic [31:0] mask;
        mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return mask;
    endfunction

    function automatic logic [4:0] top_bit_pos(input logic [12:0] vec);
        logic [4:0] pos;
        pos = 5'h00;
        for (int i = 0; i < 13; i++)
        begin
            if (vec[i])
            begin
                pos = 5'(i);
            end
        end
        return pos;
    endfunction

    // ************************************************************
    // Declarations
    // ************************************************************
    logic                        any_reset;
    sec_err_pkg::cfg_op_type     cfg_op;
    logic                        hit_flags;
    logic                        hit_mask;
    logic [31:0]                 lane_mask;
    sec_err_pkg::err_vec_type    raw_event;
    sec_err_pkg::err_vec_type    live_event;
    sec_err_pkg::err_vec_type    flag_clear;
    sec_err_pkg::err_vec_type    flags;
    logic [31:0]                 mask_reg;
    logic [31:0]                 mask_next;
    logic [31:0]                 rdata_reg;
    logic [31:0]                 rdata_next;
    logic                        ack_reg;
    logic                        ack_next;
    logic                        hit_reg;
    logic                        hit_next;
    logic [12:0]                 report_reg;
    logic [12:0]                 report_next;
    logic                        report_any_reg;
    logic                        report_any_next;
    logic [4:0]                  report_pos_reg;
    logic [4:0]                  report_pos_next;

    // ************************************************************
    // Reset sources
    // ************************************************************
    always_comb
    begin
        any_reset = rst_i | pcie_reset_i | global_reset_in_i | por_reset_i;
    end

    // ************************************************************
    // Access decode
    // ************************************************************
    always_comb
    begin
        if (cfg_wr_i)
        begin
            cfg_op = sec_err_pkg::cfg_op_write;
        end
        else if (cfg_rd_i)
        begin
            cfg_op = sec_err_pkg::cfg_op_read;
        end
        else
        begin
            cfg_op = sec_err_pkg::cfg_op_idle;
        end
        hit_flags = 1'b0;
        hit_mask  = 1'b0;
        // Word decode, byte offset bits ignored
        if ({cfg_addr_i[11:2], 2'b00} == `SEC_ERR_FLAGS_OFFSET)
        begin
            hit_flags = 1'b1;
        end
        else if ({cfg_addr_i[11:2], 2'b00} == `SEC_ERR_MASK_OFFSET)
        begin
            hit_mask = 1'b1;
        end
        lane_mask = be_expand(cfg_be_i);
    end

    // ************************************************************
    // Error events
    // ************************************************************
    err_event_capture u_capture
    (
        .clock_i                    (clock_i),
        .ce_i                       (ce_i),
        .any_reset_i                (any_reset),
        .sys_err_active_i           (sys_err_active_i),
        .parity_err_signal_active_i (parity_err_signal_active_i),
        .discard_expired_i          (discard_expired_i),
        .addr_parity_err_i          (addr_parity_err_i),
        .wr_data_parity_err_i       (wr_data_parity_err_i),
        .rd_cpl_perr_i              (rd_cpl_perr_i),
        .master_abort_i             (master_abort_i),
        .target_abort_i             (target_abort_i),
        .event_o                    (raw_event)
    );

    always_comb
    begin
        // Same bit position gates same error; PCI-X bits hit no event
        live_event = raw_event & ~mask_reg[12:0];
        flag_clear = '0;
        if (cfg_op == sec_err_pkg::cfg_op_write && hit_flags)
        begin
            flag_clear = cfg_wdata_i[12:0] & lane_mask[12:0];
        end
    end

    // ************************************************************
    // Status flags
    // ************************************************************
    w1c_flag_bank u_flags
    (
        .clock_i     (clock_i),
        .ce_i        (ce_i),
        .any_reset_i (any_reset),
        .set_i       (live_event),
        .clear_i     (flag_clear),
        .flags_o     (flags)
    );

    // ************************************************************
    // Mask register
    // ************************************************************
    always_comb
    begin
        mask_next = mask_reg;
        if (cfg_op == sec_err_pkg::cfg_op_write && hit_mask)
        begin
            mask_next = ((mask_reg & ~lane_mask) | (cfg_wdata_i & lane_mask))
                      & `SEC_ERR_MASK_IMPL;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (any_reset)
        begin
            mask_reg <= `SEC_ERR_MASK_RESET;
        end
        else if (ce_i)
        begin
            mask_reg <= mask_next;
        end
    end

    // ************************************************************
    // Read response
    // ************************************************************
    always_comb
    begin
        rdata_next = rdata_reg;
        ack_next   = 1'b0;
        hit_next   = hit_reg;
        if (cfg_op != sec_err_pkg::cfg_op_idle)
        begin
            ack_next = 1'b1;
            hit_next = hit_flags | hit_mask;
        end
        if (cfg_op == sec_err_pkg::cfg_op_read)
        begin
            if (hit_flags)
            begin
                rdata_next = {19'h0_0000, flags} & `SEC_ERR_FLAGS_IMPL;
            end
            else if (hit_mask)
            begin
                rdata_next = mask_reg & `SEC_ERR_MASK_IMPL;
            end
            else
            begin
                rdata_next = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (any_reset)
        begin
            rdata_reg <= 32'h0000_0000;
            ack_reg   <= 1'b0;
            hit_reg   <= 1'b0;
        end
        else if (ce_i)
        begin
            rdata_reg <= rdata_next;
            ack_reg   <= ack_next;
            hit_reg   <= hit_next;
        end
    end

    // ************************************************************
    // Upstream report
    // ************************************************************
    always_comb
    begin
        report_next     = live_event;
        report_any_next = |live_event;
        report_pos_next = report_pos_reg;
        if (|live_event)
        begin
            report_pos_next = top_bit_pos(live_event);
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (any_reset)
        begin
            report_reg     <= 13'h0000;
            report_any_reg <= 1'b0;
            report_pos_reg <= 5'h00;
        end
        else if (ce_i)
        begin
            report_reg     <= report_next;
            report_any_reg <= report_any_next;
            report_pos_reg <= report_pos_next;
        end
        else
        begin
            // Pulses end even while frozen
            report_reg     <= 13'h0000;
            report_any_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign cfg_rdata_o         = rdata_reg;
    assign cfg_ack_o           = ack_reg;
    assign cfg_hit_o           = hit_reg;
    assign err_report_o        = report_reg;
    assign err_report_any_o    = report_any_reg;
    assign err_report_pos_o    = report_pos_reg;
    assign sys_err_seen_flag_o = flags;

endmodule // sec_bus_err_regs

//--- design/sec_err_cfg.svh
`ifndef SEC_ERR_CFG_SVH
`define SEC_ERR_CFG_SVH

// ****************************************************************
// Register offsets in the extended configuration space
// ****************************************************************
`define SEC_ERR_FLAGS_OFFSET     12'h12c
`define SEC_ERR_MASK_OFFSET      12'h130

// ****************************************************************
// Reset values
// ****************************************************************
`define SEC_ERR_FLAGS_RESET      32'h0000_0000
`define SEC_ERR_MASK_RESET       32'h0000_17a8

// ****************************************************************
// Implemented bits
// ****************************************************************
`define SEC_ERR_FLAGS_IMPL       32'h0000_1e8c
`define SEC_ERR_MASK_IMPL        32'h0000_3fec

// ****************************************************************
// Field positions
// ****************************************************************
`define SEC_ERR_BIT_SYS_ERR      12
`define SEC_ERR_BIT_PERR_SIG     11
`define SEC_ERR_BIT_DISCARD      10
`define SEC_ERR_BIT_ADDR_PAR     9
`define SEC_ERR_BIT_DATA_PAR     7
`define SEC_ERR_BIT_MASTER_ABORT 3
`define SEC_ERR_BIT_TARGET_ABORT 2
`define SEC_ERR_VEC_WIDTH        13

`endif

//--- design/sec_err_pkg.sv
package sec_err_pkg;

    typedef logic [12:0] err_vec_type;
    typedef logic [31:0] cfg_word_type;

    typedef enum logic [1:0] {
        cfg_op_idle  = 2'b00,
        cfg_op_read  = 2'b01,
        cfg_op_write = 2'b10
    } cfg_op_type;

endpackage

//--- design/err_event_capture.sv
`timescale 1ns/1ps
`include "sec_err_cfg.svh"

module err_event_capture
(
    input  wire logic                      clock_i,
    input  wire logic                      ce_i,
    input  wire logic                      any_reset_i,
    input  wire logic                      sys_err_active_i,
    input  wire logic                      parity_err_signal_active_i,
    input  wire logic                      discard_expired_i,
    input  wire logic                      addr_parity_err_i,
    input  wire logic                      wr_data_parity_err_i,
    input  wire logic                      rd_cpl_perr_i,
    input  wire logic                      master_abort_i,
    input  wire logic                      target_abort_i,
    output sec_err_pkg::err_vec_type       event_o
);

    logic                      sys_err_reg;
    logic                      sys_err_next;
    logic                      perr_sig_reg;
    logic                      perr_sig_next;
    sec_err_pkg::err_vec_type  event_vec;

    // ************************************************************
    // Onset detection of bus signal levels
    // ************************************************************
    always_comb
    begin
        sys_err_next  = sys_err_active_i;
        perr_sig_next = parity_err_signal_active_i;
    end

    always_ff @(posedge clock_i)
    begin
        if (any_reset_i)
        begin
            sys_err_reg  <= 1'b0;
            perr_sig_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            sys_err_reg  <= sys_err_next;
            perr_sig_reg <= perr_sig_next;
        end
    end

    // ************************************************************
    // Event vector at status bit positions
    // ************************************************************
    always_comb
    begin
        event_vec = '0;
        event_vec[`SEC_ERR_BIT_SYS_ERR]      = sys_err_active_i & ~sys_err_reg;
        event_vec[`SEC_ERR_BIT_PERR_SIG]     = parity_err_signal_active_i & ~perr_sig_reg;
        event_vec[`SEC_ERR_BIT_DISCARD]      = discard_expired_i;
        event_vec[`SEC_ERR_BIT_ADDR_PAR]     = addr_parity_err_i;
        event_vec[`SEC_ERR_BIT_DATA_PAR]     = wr_data_parity_err_i | rd_cpl_perr_i;
        event_vec[`SEC_ERR_BIT_MASTER_ABORT] = master_abort_i;
        event_vec[`SEC_ERR_BIT_TARGET_ABORT] = target_abort_i;
        event_o = event_vec & ~{`SEC_ERR_VEC_WIDTH{~ce_i}};
    end

endmodule // err_event_capture

//--- design/w1c_flag_bank.sv
`timescale 1ns/1ps
`include "sec_err_cfg.svh"

module w1c_flag_bank
(
    input  wire logic                      clock_i,
    input  wire logic                      ce_i,
    input  wire logic                      any_reset_i,
    input  wire sec_err_pkg::err_vec_type  set_i,
    input  wire sec_err_pkg::err_vec_type  clear_i,
    output sec_err_pkg::err_vec_type       flags_o
);

    sec_err_pkg::err_vec_type  flags_reg;
    sec_err_pkg::err_vec_type  flags_next;

    // ************************************************************
    // Sticky flags, set wins over clear
    // ************************************************************
    always_comb
    begin
        flags_next = ((flags_reg & ~clear_i) | set_i)
                   & 13'(`SEC_ERR_FLAGS_IMPL);
    end

    always_ff @(posedge clock_i)
    begin
        if (any_reset_i)
        begin
            flags_reg <= '0;
        end
        else if (ce_i)
        begin
            flags_reg <= flags_next;
        end
    end

    assign flags_o = flags_reg;

endmodule // w1c_flag_bank

//--- test/sec_bus_err_regs_properties.sv
`timescale 1ns/1ps

module sec_bus_err_regs_properties
(
    input wire logic        clock_i,
    input wire logic        ce_i,
    input wire logic        rst_i,
    input wire logic        pcie_reset_i,
    input wire logic        global_reset_in_i,
    input wire logic        por_reset_i,
    input wire logic        cfg_rd_i,
    input wire logic        cfg_wr_i,
    input wire logic [11:0] cfg_addr_i,
    input wire logic [3:0]  cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic        cfg_ack_o,
    input wire logic [12:0] err_report_o,
    input wire logic        err_report_any_o,
    input wire logic [12:0] sys_err_seen_flag_o
);
    logic        any_rst;
    logic [31:0] be_bits;
    logic [12:0] clr_bits;
    logic        rd_status;
    logic        rd_mask;

    assign any_rst   = rst_i | pcie_reset_i | global_reset_in_i | por_reset_i;
    assign be_bits   = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
    assign clr_bits  = (ce_i && cfg_wr_i && cfg_addr_i[11:2] == 10'h04b) ?
                       (cfg_wdata_i[12:0] & be_bits[12:0]) : 13'h0000;
    assign rd_status = ce_i && cfg_rd_i && !cfg_wr_i && cfg_addr_i[11:2] == 10'h04b;
    assign rd_mask   = ce_i && cfg_rd_i && !cfg_wr_i && cfg_addr_i[11:2] == 10'h04c;

    default clocking @(posedge clock_i); endclocking
    default disable iff (any_rst);

    chk_ack_pulse: assert property ((ce_i && (cfg_rd_i || cfg_wr_i)) |=> cfg_ack_o)
        else $error("access not acknowledged");
    chk_flags_sticky: assert property (!any_rst |=> (($past(sys_err_seen_flag_o)
        & ~$past(clr_bits)) & ~sys_err_seen_flag_o) == 13'h0000)
        else $error("flag dropped without a clear");
    chk_unused_zero: assert property ((sys_err_seen_flag_o & 13'h0173) == 13'h0000)
        else $error("unused status bit set");
    chk_reset_clears: assert property (@(posedge clock_i) disable iff (1'b0)
        any_rst |=> sys_err_seen_flag_o == 13'h0000 && err_report_o == 13'h0000)
        else $error("reset left flags or reports");
    chk_status_read: assert property (rd_status |=>
        cfg_rdata_o == {19'h00000, $past(sys_err_seen_flag_o)})
        else $error("status read data wrong");
    chk_mask_reserved: assert property (rd_mask |=>
        cfg_rdata_o[31:14] == 18'h00000 && cfg_rdata_o[4] == 1'b0)
        else $error("mask reserved bits not zero");
    chk_set_reported: assert property ((sys_err_seen_flag_o & ~$past(sys_err_seen_flag_o)
        & ~err_report_o) == 13'h0000)
        else $error("flag set without report");
    chk_report_flags: assert property ((err_report_o != 13'h0000) |-> err_report_any_o
        && (sys_err_seen_flag_o & err_report_o) == err_report_o)
        else $error("report without flag");
endmodule // sec_bus_err_regs_properties

bind sec_bus_err_regs sec_bus_err_regs_properties i_sec_bus_err_regs_properties
(
    .clock_i(clock_i), .ce_i(ce_i), .rst_i(rst_i), .pcie_reset_i(pcie_reset_i),
    .global_reset_in_i(global_reset_in_i), .por_reset_i(por_reset_i),
    .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
    .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
    .cfg_ack_o(cfg_ack_o), .err_report_o(err_report_o),
    .err_report_any_o(err_report_any_o), .sys_err_seen_flag_o(sys_err_seen_flag_o)
);

//--- test/sec_bus_agent_model.sv
`timescale 1ns/1ps

module sec_bus_agent_model
(
    input  wire logic [7:0] fire_i,
    input  wire logic [1:0] len_i,
    input  wire logic       clock_i,
    output logic      [7:0] ev_o
);
    logic [7:0] act = 8'h00;
    logic [1:0] cnt = 2'h0;

    // Order: serr, perr, discard, addr par, wr par, rd perr, m-abort, t-abort
    always @(posedge clock_i)
    begin
        if (fire_i != 8'h00)
        begin
            act <= fire_i;
            cnt <= len_i;
        end
        else if (cnt > 2'h1)
            cnt <= cnt - 2'h1;
        else
            act <= 8'h00;
    end

    assign ev_o = act;
endmodule // sec_bus_agent_model

//--- test/sec_bus_err_regs_tb.sv
`timescale 1ns/1ps

module sec_bus_err_regs_tb;
    logic        clock_i;
    logic        ce_i;
    logic [3:0]  rvec;
    logic        cfg_rd_i;
    logic        cfg_wr_i;
    logic [11:0] cfg_addr_i;
    logic [3:0]  cfg_be_i;
    logic [31:0] cfg_wdata_i;
    logic [31:0] cfg_rdata_o;
    logic        cfg_ack_o;
    logic        cfg_hit_o;
    logic [7:0]  ev;
    logic [7:0]  fire;
    logic [1:0]  len;
    logic [12:0] err_report_o;
    logic        err_report_any_o;
    logic [4:0]  err_report_pos_o;
    logic [12:0] sys_err_seen_flag_o;
    logic [12:0] rep_seen;
    logic        rep_any;
    int          fails = 0;
    int          num_checks = 0;
    int          src_bit [8] = '{12, 11, 10, 9, 7, 7, 3, 2};

    sec_bus_agent_model i_sec_bus_agent_model
    (
        .fire_i(fire), .len_i(len), .clock_i(clock_i), .ev_o(ev)
    );

    sec_bus_err_regs i_sec_bus_err_regs
    (
        .clock_i(clock_i), .ce_i(ce_i), .rst_i(rvec[0]), .pcie_reset_i(rvec[1]),
        .global_reset_in_i(rvec[2]), .por_reset_i(rvec[3]),
        .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
        .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
        .cfg_ack_o(cfg_ack_o), .cfg_hit_o(cfg_hit_o),
        .sys_err_active_i(ev[7]), .parity_err_signal_active_i(ev[6]),
        .discard_expired_i(ev[5]), .addr_parity_err_i(ev[4]),
        .wr_data_parity_err_i(ev[3]), .rd_cpl_perr_i(ev[2]),
        .master_abort_i(ev[1]), .target_abort_i(ev[0]),
        .err_report_o(err_report_o), .err_report_any_o(err_report_any_o),
        .err_report_pos_o(err_report_pos_o), .sys_err_seen_flag_o(sys_err_seen_flag_o)
    );

    // ****************************************************************
    // Access and check tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic access(input logic w, input logic [11:0] a, input logic [3:0] b,
                          input logic [31:0] d);
        @(posedge clock_i);
        cfg_wr_i    <= w;
        cfg_rd_i    <= ~w;
        cfg_addr_i  <= a;
        cfg_be_i    <= b;
        cfg_wdata_i <= d;
        @(posedge clock_i);
        cfg_wr_i <= 1'b0;
        cfg_rd_i <= 1'b0;
        #1;
        check({31'h0, cfg_ack_o}, 32'h1);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        access(1'b0, a, 4'h0, 32'h0);
        check(cfg_rdata_o, exp);
    endtask

    task automatic fire_ev(input logic [7:0] v, input logic [1:0] n);
        rep_seen = 13'h0000;
        rep_any  = 1'b0;
        @(posedge clock_i);
        fire <= v;
        len  <= n;
        @(posedge clock_i);
        fire <= 8'h00;
        repeat (6)
        begin
            @(negedge clock_i);
            rep_seen = rep_seen | err_report_o;
            rep_any  = rep_any | err_report_any_o;
            @(posedge clock_i);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    initial
    begin
        repeat (5000) @(posedge clock_i);
        fails++;
        print_verdict();
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial
    begin
        ce_i = 1'b1;
        rvec = 4'h1;
        cfg_rd_i = 1'b0;
        cfg_wr_i = 1'b0;
        cfg_addr_i = 12'h000;
        cfg_be_i = 4'h0;
        cfg_wdata_i = 32'h0;
        fire = 8'h00;
        len = 2'h1;
        repeat (10) @(posedge clock_i);
        rvec <= 4'h0;
        @(posedge clock_i);
        rd_chk(12'h12c, 32'h0);
        check({31'h0, cfg_hit_o}, 32'h1);
        rd_chk(12'h130, 32'h17a8);
        rd_chk(12'h200, 32'h0);
        check({31'h0, cfg_hit_o}, 32'h0);
        access(1'b1, 12'h130, 4'hf, 32'hffffffff);
        rd_chk(12'h130, 32'h3fec);
        access(1'b1, 12'h130, 4'hf, 32'h0);
        for (int k = 0; k < 8; k++)
        begin
            fire_ev(8'h80 >> k, 2'h1);
            check({19'h0, rep_seen}, 32'h1 << src_bit[k]);
            check({31'h0, rep_any}, 32'h1);
            rd_chk(12'h12c, 32'h1 << src_bit[k]);
            check({27'h0, err_report_pos_o}, 32'(src_bit[k]));
            access(1'b1, 12'h12c, 4'hf, 32'hffffffff);
            rd_chk(12'h12c, 32'h0);
        end
        fire_ev(8'h80, 2'h3);
        rd_chk(12'h12c, 32'h1000);
        fire_ev(8'h01, 2'h1);
        access(1'b1, 12'h12c, 4'hf, 32'h0);
        rd_chk(12'h12c, 32'h1004);
        access(1'b1, 12'h12c, 4'hc, 32'h1004);
        rd_chk(12'h12c, 32'h1004);
        access(1'b1, 12'h12c, 4'h1, 32'h4);
        rd_chk(12'h12c, 32'h1000);
        @(posedge clock_i);
        ce_i <= 1'b0;
        fire_ev(8'h01, 2'h1);
        ce_i <= 1'b1;
        check({19'h0, rep_seen}, 32'h0);
        rd_chk(12'h12c, 32'h1000);
        access(1'b1, 12'h130, 4'hf, 32'h2160);
        fire_ev(8'hff, 2'h1);
        check({19'h0, rep_seen}, 32'h1e8c);
        rd_chk(12'h12c, 32'h1e8c);
        for (int r = 0; r < 4; r++)
        begin
            @(posedge clock_i);
            rvec <= 4'h1 << r;
            @(posedge clock_i);
            rvec <= 4'h0;
            repeat (2) @(posedge clock_i);
            rd_chk(12'h12c, 32'h0);
            rd_chk(12'h130, 32'h17a8);
            fire_ev(8'hff, 2'h1);
            check({19'h0, rep_seen}, 32'h0804);
            rd_chk(12'h12c, 32'h0804);
            check({27'h0, err_report_pos_o}, 32'd11);
        end
        print_verdict();
    end
endmodule // sec_bus_err_regs_tb
